// File: core/smsa_pkg.sv
// Purpose: Shared constants and types for the serial management link of a switch.
// Assumes: ref_clk at 100 MHz on both ends.
// Notes on behaviour
// - Controller keeps management clock at most 5 MHz.
// - Standard frames reach eight 16-bit registers.
// - Controller makes clock and every frame.
// - Both frame types share one clock, one data line.
// - Opcode 00, address bit4 one: extended read.
// - Opcode 00, address bit4 zero: extended write.
// - Address bit3 ignored on extended access.
// - Target = low three address bits, register bits.
// - Read turnaround: controller releases, device drives zero.
// - Write turnaround: controller drives one then zero.
// - Extended registers carry eight bits, low byte.
// - Extended read returns zero upper byte, then value.
// - Extended write ignores upper byte.
// - Extended reaches 0x00..0xC6 plus transceiver registers.
// - Preamble 32 ones, start 01, fields, turnaround, data.
package smsa_pkg;
  localparam int CLK_KHZ = 100000;
  localparam int MDC_MAX_KHZ = 5000;
  // Least half period of the management clock, rounded up
  localparam int MDC_HALF_CYC = (CLK_KHZ + 2 * MDC_MAX_KHZ - 1) / (2 * MDC_MAX_KHZ);
  localparam int PRE_LEN = 32;
  localparam int HDR_LEN = 14;
  localparam int DATA_LEN = 16;
  localparam int FRAME_LEN = 64;
  localparam int TA_POS = 46;
  localparam int DATA_POS = 48;
  localparam int SOF_HI = 13;
  localparam int OP_HI = 11;
  localparam int PA_HI = 9;
  localparam int RA_HI = 4;
  localparam int PA_RD_BIT = 4;
  localparam int EXT_HI_BITS = 3;
  localparam logic [1:0] SOF = 2'h1;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] TA_WR = 2'h2;
  localparam logic [1:0] TA_RD = 2'h3;
  localparam logic [7:0] CFG_LAST = 8'hC6;
  localparam logic [7:0] MIIM_WIN_BASE = 8'hD0;
  localparam logic [7:0] MIIM_WIN_MASK = 8'hF0;
  localparam logic [4:0] STD_REG_LAST = 5'h05;
  localparam logic [4:0] CUST_REG_A = 5'h1D;
  localparam logic [4:0] CUST_REG_B = 5'h1F;
  localparam logic [2:0] SLOT_CUST_A = 3'h6;
  localparam logic [2:0] SLOT_CUST_B = 3'h7;
  localparam logic [2:0] SLOT_STATUS = 3'h1;
  localparam logic [4:0] DEF_PHY_ADDR = 5'h01;
  typedef enum logic [1:0] {SMSA_STD_RD, SMSA_STD_WR, SMSA_EXT_RD, SMSA_EXT_WR} smsa_cmd_e;
endpackage

// File: core/smsa_mgmt_if.sv
// Purpose: Shared management clock and data wire between controller and device.
// Assumes: Data line has a pull-up, so an undriven line reads one.
// Notes: Clock is driven only by the controller.
interface smsa_mgmt_if;
  logic mgmt_clock_pin;
  logic host_data_out;
  logic host_data_oe;
  logic dev_data_out;
  logic dev_data_oe;
  logic mgmt_data_pin;
  // Resolved wire level, pull-up when nobody drives
  assign mgmt_data_pin = host_data_oe ? host_data_out : (dev_data_oe ? dev_data_out : 1'b1);
  modport host (output mgmt_clock_pin, output host_data_out, output host_data_oe,
    input mgmt_data_pin);
  modport device (input mgmt_clock_pin, input mgmt_data_pin, output dev_data_out,
    output dev_data_oe);
endinterface

// File: core/smsa_device.sv
// Purpose: Management slave: standard frames and extended register frames.
// Assumes: Clock and data pins are asynchronous; both pass two flip-flops.
// Notes: Transceiver registers also appear in an extended byte window.
module smsa_device #(
  parameter logic [4:0] PHY_ADDR = smsa_pkg::DEF_PHY_ADDR
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  smsa_mgmt_if.device mif,
  input wire logic [15:0] phy_status,
  output logic wr_strobe,
  output logic wr_ext,
  output logic [7:0] wr_addr,
  output logic [15:0] wr_data,
  output logic frame_active
);
  typedef enum logic [1:0] {SMSA_PRE, SMSA_HDR, SMSA_TA, SMSA_DATA} smsa_dstate_e;
  typedef enum logic [2:0] {SMSA_K_NONE, SMSA_K_STD_RD, SMSA_K_STD_WR, SMSA_K_EXT_RD,
    SMSA_K_EXT_WR} smsa_kind_e;
  localparam int NCFG = int'(smsa_pkg::CFG_LAST) + 1;
  logic [2:0] mdc_sy, mdio_sy;
  logic mdc_rise, mdc_fall, bit_in, commit, hdr_done, is_rd, win_hit;
  smsa_dstate_e state;
  logic [5:0] cnt, pre_cnt;
  logic [smsa_pkg::HDR_LEN-1:0] hdr, next_hdr;
  logic [smsa_pkg::DATA_LEN-1:0] wbuf, rd_sh;
  smsa_kind_e kind_q, next_kind;
  logic [7:0] addr_q, next_addr;
  logic [2:0] slot_q, next_slot, win_slot;
  logic slot_ok_q, next_slot_ok;
  logic [7:0] cfg [NCFG];
  logic [15:0] phy_reg [8];
  logic [15:0] next_rd, commit_data;
  // Clock and data both cross in here
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mdc_sy <= 3'h0;
      mdio_sy <= 3'h7;
    end
    else
    begin
      mdc_sy <= {mdc_sy[1:0], mif.mgmt_clock_pin};
      mdio_sy <= {mdio_sy[1:0], mif.mgmt_data_pin};
    end
  end
  assign mdc_rise = mdc_sy[1] & ~mdc_sy[2];
  assign mdc_fall = ~mdc_sy[1] & mdc_sy[2];
  assign bit_in = mdio_sy[1];
  assign hdr_done = mdc_rise && state == SMSA_HDR && cnt == 6'(smsa_pkg::HDR_LEN - 1);
  // Header decode on the bit that completes it
  always_comb
  begin
    next_hdr = {hdr[smsa_pkg::HDR_LEN-2:0], bit_in};
    // Address bit 3 never reaches the address
    next_addr = {next_hdr[smsa_pkg::PA_HI-2 -: smsa_pkg::EXT_HI_BITS],
      next_hdr[smsa_pkg::RA_HI -: 5]};
    next_kind = SMSA_K_NONE;
    if (next_hdr[smsa_pkg::SOF_HI -: 2] == smsa_pkg::SOF)
    begin
      if (next_hdr[smsa_pkg::OP_HI -: 2] == smsa_pkg::OP_EXT)
      begin
        if (next_hdr[smsa_pkg::PA_HI - 4 + smsa_pkg::PA_RD_BIT])
          next_kind = SMSA_K_EXT_RD;
        else
          next_kind = SMSA_K_EXT_WR;
      end
      else if (next_hdr[smsa_pkg::PA_HI -: 5] == PHY_ADDR)
      begin
        if (next_hdr[smsa_pkg::OP_HI -: 2] == smsa_pkg::OP_RD)
          next_kind = SMSA_K_STD_RD;
        else if (next_hdr[smsa_pkg::OP_HI -: 2] == smsa_pkg::OP_WR)
          next_kind = SMSA_K_STD_WR;
      end
    end
  end
  // Eight transceiver slots: indices 0..5, 29, 31
  always_comb
  begin
    next_slot = next_hdr[2:0];
    next_slot_ok = 1'b0;
    if (next_hdr[smsa_pkg::RA_HI -: 5] <= smsa_pkg::STD_REG_LAST)
      next_slot_ok = 1'b1;
    else if (next_hdr[smsa_pkg::RA_HI -: 5] == smsa_pkg::CUST_REG_A)
    begin
      next_slot = smsa_pkg::SLOT_CUST_A;
      next_slot_ok = 1'b1;
    end
    else if (next_hdr[smsa_pkg::RA_HI -: 5] == smsa_pkg::CUST_REG_B)
    begin
      next_slot = smsa_pkg::SLOT_CUST_B;
      next_slot_ok = 1'b1;
    end
  end
  assign win_hit = (next_addr & smsa_pkg::MIIM_WIN_MASK) == smsa_pkg::MIIM_WIN_BASE;
  assign win_slot = next_addr[3:1];
  // Read value captured when the header completes
  always_comb
  begin
    next_rd = 16'h0000;
    if (next_kind == SMSA_K_EXT_RD)
    begin
      if (next_addr <= smsa_pkg::CFG_LAST)
        next_rd = {8'h00, cfg[next_addr]};
      else if (win_hit && win_slot == smsa_pkg::SLOT_STATUS)
        next_rd = {8'h00, next_addr[0] ? phy_status[15:8] : phy_status[7:0]};
      else if (win_hit)
        next_rd = {8'h00, next_addr[0] ? phy_reg[win_slot][15:8]
          : phy_reg[win_slot][7:0]};
    end
    else if (next_kind == SMSA_K_STD_RD && next_slot_ok)
      next_rd = next_slot == smsa_pkg::SLOT_STATUS ? phy_status : phy_reg[next_slot];
  end

  // Frame walker: preamble, header, turnaround, data
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= SMSA_PRE;
      cnt <= 6'h00;
      pre_cnt <= 6'h00;
      hdr <= '0;
      wbuf <= '0;
      kind_q <= SMSA_K_NONE;
      addr_q <= 8'h00;
      slot_q <= 3'h0;
      slot_ok_q <= 1'b0;
    end
    else if (mdc_rise)
    begin
      unique case (state)
        SMSA_PRE:
        begin
          if (bit_in)
          begin
            if (pre_cnt != 6'(smsa_pkg::PRE_LEN))
              pre_cnt <= pre_cnt + 6'h01;
          end
          else if (pre_cnt == 6'(smsa_pkg::PRE_LEN))
          begin
            state <= SMSA_HDR;
            hdr <= '0;
            cnt <= 6'h01;
            pre_cnt <= 6'h00;
          end
          else
            pre_cnt <= 6'h00;
        end
        SMSA_HDR:
        begin
          hdr <= next_hdr;
          cnt <= cnt + 6'h01;
          if (hdr_done)
          begin
            kind_q <= next_kind;
            addr_q <= next_addr;
            slot_q <= next_slot;
            slot_ok_q <= next_slot_ok;
            cnt <= 6'h00;
            state <= next_kind == SMSA_K_NONE ? SMSA_PRE : SMSA_TA;
          end
        end
        SMSA_TA:
        begin
          cnt <= cnt + 6'h01;
          if (cnt == 6'h01)
          begin
            cnt <= 6'h00;
            state <= SMSA_DATA;
          end
        end
        SMSA_DATA:
        begin
          wbuf <= {wbuf[smsa_pkg::DATA_LEN-2:0], bit_in};
          cnt <= cnt + 6'h01;
          if (cnt == 6'(smsa_pkg::DATA_LEN - 1))
          begin
            cnt <= 6'h00;
            state <= SMSA_PRE;
          end
        end
      endcase
    end
  end
  assign is_rd = kind_q == SMSA_K_EXT_RD || kind_q == SMSA_K_STD_RD;
  assign commit = mdc_rise && state == SMSA_DATA && cnt == 6'(smsa_pkg::DATA_LEN - 1)
    && (kind_q == SMSA_K_EXT_WR || kind_q == SMSA_K_STD_WR);
  assign commit_data = {wbuf[smsa_pkg::DATA_LEN-2:0], bit_in};

  // Pin drive changes only on falling clock edges
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_sh <= '0;
      mif.dev_data_out <= 1'b0;
      mif.dev_data_oe <= 1'b0;
    end
    else if (hdr_done)
      rd_sh <= next_rd;
    else if (mdc_fall)
    begin
      if (is_rd && state == SMSA_TA && cnt == 6'h01)
      begin
        mif.dev_data_out <= 1'b0;
        mif.dev_data_oe <= 1'b1;
      end
      else if (is_rd && state == SMSA_DATA)
      begin
        mif.dev_data_out <= rd_sh[smsa_pkg::DATA_LEN-1];
        mif.dev_data_oe <= 1'b1;
        rd_sh <= {rd_sh[smsa_pkg::DATA_LEN-2:0], 1'b0};
      end
      else
      begin
        mif.dev_data_out <= 1'b0;
        mif.dev_data_oe <= 1'b0;
      end
    end
  end
  // Register storage; status slot is read-only
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NCFG; i++)
        cfg[i] <= 8'h00;
      for (int i = 0; i < 8; i++)
        phy_reg[i] <= 16'h0000;
    end
    else if (commit && kind_q == SMSA_K_EXT_WR)
    begin
      if (addr_q <= smsa_pkg::CFG_LAST)
        cfg[addr_q] <= commit_data[7:0];
      else if ((addr_q & smsa_pkg::MIIM_WIN_MASK) == smsa_pkg::MIIM_WIN_BASE
        && addr_q[3:1] != smsa_pkg::SLOT_STATUS)
      begin
        if (addr_q[0])
          phy_reg[addr_q[3:1]][15:8] <= commit_data[7:0];
        else
          phy_reg[addr_q[3:1]][7:0] <= commit_data[7:0];
      end
    end
    else if (commit && slot_ok_q && slot_q != smsa_pkg::SLOT_STATUS)
      phy_reg[slot_q] <= commit_data;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_strobe <= 1'b0;
      wr_ext <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 16'h0000;
      frame_active <= 1'b0;
    end
    else
    begin
      wr_strobe <= commit;
      frame_active <= state != SMSA_PRE;
      if (commit)
      begin
        wr_ext <= kind_q == SMSA_K_EXT_WR;
        wr_addr <= kind_q == SMSA_K_EXT_WR ? addr_q : {3'h0, hdr[smsa_pkg::RA_HI -: 5]};
        wr_data <= kind_q == SMSA_K_EXT_WR ? {8'h00, commit_data[7:0]} : commit_data;
      end
    end
  end
endmodule

// File: core/smsa_host.sv
// Purpose: Management controller: builds frames, makes the management clock.
// Assumes: One command at a time; device answers within a half period.
// Notes: Clock is derived from ref_clk by a divider and stays low when idle.
module smsa_host #(
  parameter int MDC_HALF = smsa_pkg::MDC_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  smsa_mgmt_if.host mif,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire smsa_pkg::smsa_cmd_e cmd_kind,
  input wire logic [4:0] cmd_phy,
  input wire logic [4:0] cmd_reg,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata
);
  if (MDC_HALF < smsa_pkg::MDC_HALF_CYC || MDC_HALF > 255)
  begin : g_chk
    $error("MDC_HALF out of range");
  end

  logic [1:0] mdio_sy;
  logic busy;
  logic is_rd;
  logic [7:0] div;
  logic [6:0] bit_cnt;
  logic [smsa_pkg::FRAME_LEN-1:0] frm;
  logic [1:0] next_op;
  logic [4:0] next_pa;
  logic [smsa_pkg::FRAME_LEN-1:0] next_frm;
  logic next_rd;
  logic tick;

  assign cmd_ready = ~busy;
  assign tick = busy && div == 8'(MDC_HALF - 1);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      mdio_sy <= 2'h3;
    else
      mdio_sy <= {mdio_sy[0], mif.mgmt_data_pin};
  end

  always_comb
  begin
    next_rd = cmd_kind == smsa_pkg::SMSA_STD_RD || cmd_kind == smsa_pkg::SMSA_EXT_RD;
    next_pa = cmd_phy;
    unique case (cmd_kind)
      smsa_pkg::SMSA_STD_RD: next_op = smsa_pkg::OP_RD;
      smsa_pkg::SMSA_STD_WR: next_op = smsa_pkg::OP_WR;
      smsa_pkg::SMSA_EXT_RD:
      begin
        next_op = smsa_pkg::OP_EXT;
        next_pa[smsa_pkg::PA_RD_BIT] = 1'b1;
      end
      smsa_pkg::SMSA_EXT_WR:
      begin
        next_op = smsa_pkg::OP_EXT;
        next_pa[smsa_pkg::PA_RD_BIT] = 1'b0;
      end
    endcase
    next_frm = {{smsa_pkg::PRE_LEN{1'b1}}, smsa_pkg::SOF, next_op, next_pa, cmd_reg,
      next_rd ? smsa_pkg::TA_RD : smsa_pkg::TA_WR, cmd_wdata};
  end

  // Frame engine: bits change after falling edges, read data taken at rising
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy <= 1'b0;
      is_rd <= 1'b0;
      div <= 8'h00;
      bit_cnt <= 7'h00;
      frm <= '0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      mif.mgmt_clock_pin <= 1'b0;
      mif.host_data_out <= 1'b0;
      mif.host_data_oe <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (!busy)
      begin
        if (cmd_valid)
        begin
          busy <= 1'b1;
          is_rd <= next_rd;
          div <= 8'h00;
          mif.host_data_out <= next_frm[smsa_pkg::FRAME_LEN-1];
          mif.host_data_oe <= 1'b1;
          frm <= {next_frm[smsa_pkg::FRAME_LEN-2:0], 1'b0};
          bit_cnt <= 7'h01;
        end
      end
      else if (!tick)
        div <= div + 8'h01;
      else
      begin
        div <= 8'h00;
        mif.mgmt_clock_pin <= ~mif.mgmt_clock_pin;
        if (!mif.mgmt_clock_pin)
        begin
          if (is_rd && bit_cnt > 7'(smsa_pkg::DATA_POS))
            rsp_rdata <= {rsp_rdata[14:0], mdio_sy[1]};
        end
        else if (bit_cnt == 7'(smsa_pkg::FRAME_LEN))
        begin
          busy <= 1'b0;
          mif.host_data_oe <= 1'b0;
          mif.host_data_out <= 1'b0;
          rsp_valid <= 1'b1;
          if (!is_rd)
            rsp_rdata <= 16'h0000;
        end
        else
        begin
          mif.host_data_out <= frm[smsa_pkg::FRAME_LEN-1];
          // Release the line for turnaround and read data
          mif.host_data_oe <= ~(is_rd && bit_cnt >= 7'(smsa_pkg::TA_POS));
          frm <= {frm[smsa_pkg::FRAME_LEN-2:0], 1'b0};
          bit_cnt <= bit_cnt + 7'h01;
        end
      end
    end
  end
endmodule

// File: verif/smsa_checker.sv
// Purpose: Assertions on the shared management clock and data wire.
// Assumes: The host makes the clock from ref_clk.
// Notes: Counters measure clock runs, preamble and drive length.
module smsa_checker #(
  parameter int MIN_HALF = 10
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic mgmt_clock_pin,
  input wire logic host_data_out,
  input wire logic host_data_oe,
  input wire logic dev_data_out,
  input wire logic dev_data_oe,
  input wire logic mgmt_data_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_q;
  logic clk_rise;
  logic in_pre;
  logic [7:0] run_len;
  logic [5:0] ones;
  logic [5:0] drv_rises;
  assign clk_rise = mgmt_clock_pin && !clk_q;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clk_q <= 1'b0;
      run_len <= 8'h00;
    end
    else
    begin
      clk_q <= mgmt_clock_pin;
      if (mgmt_clock_pin != clk_q)
        run_len <= 8'h00;
      else if (run_len != 8'hFF)
        run_len <= run_len + 8'h01;
    end
  end
  // Ones seen since the host took the line
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_pre <= 1'b0;
      ones <= 6'h00;
    end
    else if (!host_data_oe)
    begin
      in_pre <= 1'b1;
      ones <= 6'h00;
    end
    else if (clk_rise && mgmt_data_pin)
      ones <= ones + 6'h01;
    else if (clk_rise)
      in_pre <= 1'b0;
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      drv_rises <= 6'h00;
    else if (!dev_data_oe)
      drv_rises <= 6'h00;
    else if (clk_rise)
      drv_rises <= drv_rises + 6'h01;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  clock_half_a: assert property (
    mgmt_clock_pin != clk_q |-> run_len >= MIN_HALF - 1)
    else $error("management clock half period too short");
  no_contention_a: assert property (!(host_data_oe && dev_data_oe))
    else $error("both ends drive the data line");
  turn_zero_a: assert property (
    $rose(dev_data_oe) |-> !dev_data_out && !$past(host_data_oe, 8))
    else $error("turnaround bit from device is not zero");
  drive_len_a: assert property ($fell(dev_data_oe) |-> drv_rises == 6'h11)
    else $error("device drove a wrong number of bits");
  preamble_len_a: assert property (
    in_pre && host_data_oe && clk_rise && !mgmt_data_pin |-> ones == 6'h20)
    else $error("preamble length wrong");
  host_setup_a: assert property (
    $rose(mgmt_clock_pin) && host_data_oe |-> $stable(host_data_out) [*8])
    else $error("host data moved near rising clock");
  dev_hold_a: assert property (
    dev_data_oe && $changed(dev_data_out) |-> !mgmt_clock_pin && !$past(mgmt_clock_pin))
    else $error("device data moved while clock high");
  dev_release_a: assert property (
    $fell(dev_data_oe) |-> !mgmt_clock_pin && !host_data_oe)
    else $error("device released line at wrong moment");
  reset_idle_a: assert property (disable iff (1'b0)
    !reset_n |-> !mgmt_clock_pin && !host_data_oe && !dev_data_oe)
    else $error("wire not idle in reset");
endmodule

// File: verif/switch_mgmt_serial_access_test.sv
// Purpose: Bench joining controller and device over the management wire.
// Assumes: Default divider, device at its default address.
// Notes: An unanswered read returns all ones through the pull-up.
module switch_mgmt_serial_access_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  localparam logic [4:0] own_phy = smsa_pkg::DEF_PHY_ADDR;
  logic reset_n = 1'b1;
  logic cmd_valid = 1'b0;
  smsa_pkg::smsa_cmd_e cmd_kind = smsa_pkg::SMSA_STD_RD;
  logic [4:0] cmd_phy = 5'h00;
  logic [4:0] cmd_reg = 5'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [15:0] phy_status = 16'hBEEF;
  logic cmd_ready, rsp_valid, wr_strobe, wr_ext, frame_active, seen_ext;
  logic [15:0] rsp_rdata, wr_data, seen_data, rd;
  logic [7:0] wr_addr, seen_addr;
  logic [7:0] a_tab [3] = '{8'h00, 8'h35, 8'hC6};
  logic [4:0] r_tab [7] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1D, 5'h1F};
  int miscompares = 0;
  int n_compared = 0;
  int strobes = 0;
  smsa_mgmt_if mif ();
  always #5 ref_clk = ~ref_clk;
  smsa_host u_smsa_host (.ref_clk(ref_clk), .reset_n(reset_n), .mif(mif), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_phy(cmd_phy), .cmd_reg(cmd_reg),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  smsa_device u_smsa_device (.ref_clk(ref_clk), .reset_n(reset_n), .mif(mif),
    .phy_status(phy_status), .wr_strobe(wr_strobe), .wr_ext(wr_ext), .wr_addr(wr_addr),
    .wr_data(wr_data), .frame_active(frame_active));
  smsa_checker #(.MIN_HALF(smsa_pkg::MDC_HALF_CYC)) u_smsa_checker (.ref_clk(ref_clk),
    .reset_n(reset_n), .mgmt_clock_pin(mif.mgmt_clock_pin), .host_data_out(mif.host_data_out),
    .host_data_oe(mif.host_data_oe), .dev_data_out(mif.dev_data_out),
    .dev_data_oe(mif.dev_data_oe), .mgmt_data_pin(mif.mgmt_data_pin));
  // Latch each write notice from the device
  always @(negedge ref_clk)
  begin
    if (wr_strobe === 1'b1)
    begin
      strobes <= strobes + 1;
      seen_ext <= wr_ext;
      seen_addr <= wr_addr;
      seen_data <= wr_data;
    end
  end
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic do_cmd(input smsa_pkg::smsa_cmd_e k, input logic [4:0] p, input logic [4:0] r,
    input logic [15:0] w);
    int n;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_phy <= p;
    cmd_reg <= r;
    cmd_wdata <= w;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    repeat (760) @(negedge ref_clk);
    chk1(frame_active, 1'b1);
    chk1(cmd_ready, 1'b0);
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 600);
    chk1(rsp_valid, 1'b1);
    rd = rsp_rdata;
    repeat (20) @(negedge ref_clk);
    chk1(frame_active, 1'b0);
    chk1(cmd_ready, 1'b1);
  endtask
  task automatic ext_wr(input logic [7:0] a, input logic b3, input logic [15:0] d);
    int s;
    s = strobes;
    do_cmd(smsa_pkg::SMSA_EXT_WR, {1'b0, b3, a[7:5]}, a[4:0], d);
    chk16(16'(strobes - s), 16'h0001);
    chk16(rd, 16'h0000);
    chk1(seen_ext, 1'b1);
    chk16({8'h00, seen_addr}, {8'h00, a});
    chk16(seen_data, {8'h00, d[7:0]});
  endtask
  task automatic ext_rd(input logic [7:0] a, input logic b3, input logic [15:0] exp);
    do_cmd(smsa_pkg::SMSA_EXT_RD, {1'b1, b3, a[7:5]}, a[4:0], 16'h0000);
    chk16(rd, exp);
  endtask
  task automatic std_rd(input logic [4:0] p, input logic [4:0] r, input logic [15:0] exp);
    do_cmd(smsa_pkg::SMSA_STD_RD, p, r, 16'h0000);
    chk16(rd, exp);
  endtask
  initial
  begin
    // Falling edge at time zero puts every register into reset
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    ext_rd(8'h35, 1'b0, 16'h0000);
    for (int i = 0; i < 3; i++)
      ext_wr(a_tab[i], i[0], {8'hFF, a_tab[i] ^ 8'h3C});
    for (int i = 0; i < 3; i++)
      ext_rd(a_tab[i], ~i[0], {8'h00, a_tab[i] ^ 8'h3C});
    do_cmd(smsa_pkg::SMSA_EXT_WR, 5'h06, 5'h07, 16'h0033);
    ext_rd(8'hC7, 1'b0, 16'h0000);
    for (int i = 0; i < 7; i++)
    begin
      do_cmd(smsa_pkg::SMSA_STD_WR, own_phy, r_tab[i], {r_tab[i], 11'h2A5});
      chk1(seen_ext, 1'b0);
      chk16({8'h00, seen_addr}, {11'h000, r_tab[i]});
      chk16(seen_data, {r_tab[i], 11'h2A5});
    end
    for (int i = 0; i < 7; i++)
      std_rd(own_phy, r_tab[i], {r_tab[i], 11'h2A5});
    do_cmd(smsa_pkg::SMSA_STD_WR, own_phy, 5'h01, 16'h1234);
    std_rd(own_phy, 5'h01, 16'hBEEF);
    std_rd(own_phy, 5'h06, 16'h0000);
    begin
      int s;
      s = strobes;
      do_cmd(smsa_pkg::SMSA_STD_WR, 5'h02, 5'h00, 16'hFFFF);
      chk16(16'(strobes - s), 16'h0000);
    end
    std_rd(5'h02, 5'h00, 16'hFFFF);
    std_rd(own_phy, 5'h00, 16'h02A5);
    ext_rd(8'hDD, 1'b1, 16'h00EA);
    ext_rd(8'hDC, 1'b0, 16'h00A5);
    ext_rd(8'hD3, 1'b1, 16'h00BE);
    give_verdict();
  end
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    give_verdict();
  end
endmodule
